// ### include/wew_pkg.sv
// Package of constants and types for the watchdog early-warning controller
// Contract
// - Early warning fires 8 << code watchdog cycles after period start; codes 12-15 reserved
// - Delay code presets at start-up from the non-volatile user row value
// - Writing one to clear-register bit 0 clears the early-warning enable
// - Writing zero to that bit leaves the enable unchanged
// - Set and clear registers read back the same single enable state
// - One write to the clear register disables an interrupt, no read-modify-write
`default_nettype none
package wew_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] WEW_IDX_CTRL = 8'h02;
  localparam logic [7:0] WEW_IDX_ENCLR = 8'h04;
  localparam logic [7:0] WEW_IDX_ENSET = 8'h05;
  localparam logic [7:0] WEW_IDX_FLAG = 8'h06;
  localparam logic [7:0] WEW_IDX_PERIOD = 8'h07;
  localparam logic [7:0] WEW_IDX_STAT = 8'h08;
  localparam logic [7:0] WEW_IDX_MASK = 8'h09;
  // Fields
  localparam int WEW_CODE_W = 4;
  localparam int WEW_EW_BIT = 0;
  localparam int WEW_CNT_W = 16;
  localparam logic [3:0] WEW_CODE_MAX = 4'hB;
  localparam logic [WEW_CNT_W-1:0] WEW_BASE_CYC = 16'h0008;
  // Reset values
  localparam logic [WEW_CNT_W-1:0] WEW_PERIOD_RST = 16'hFFFF;
  localparam logic WEW_EN_RST = 1'b0;
  // Count clock divider: watchdog count clock is an enable pulse every N cycles
  localparam logic [7:0] WEW_DIV_N = 8'h01;
  typedef enum logic [1:0] {WEW_IDLE, WEW_RUN} wew_state_t;
endpackage : wew_pkg
`default_nettype wire

// ### rtl/wew_tick.sv
// Divider that makes the watchdog count clock enable pulse
`default_nettype none
module wew_tick
  import wew_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [7:0] cnt_reg;
  // One-cycle pulse each WEW_DIV_N clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cnt_reg >= WEW_DIV_N - 8'h01)
    begin
      cnt_reg <= 8'h00;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt_reg >= WEW_DIV_N - 8'h01);
    end
  end
endmodule : wew_tick
`default_nettype wire

// ### rtl/wew_top.sv
// Watchdog early-warning controller with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite register port.
`default_nettype none
module wew_top
  import wew_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Non-volatile user row value for the delay code
  input wire logic [3:0] NVM_CODE_I,
  // Period start from the watchdog core
  input wire logic PERIOD_START_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Interrupts and status
  output logic EW_IRQ_O,
  output logic IRQ_O
);
  import wew_pkg::*;

  logic tick;
  logic [3:0] early_warning_delay_code_reg;
  logic early_warning_irq_enable_reg;
  logic ew_flag_reg;
  logic [WEW_CNT_W-1:0] cnt_reg;
  logic [WEW_CNT_W-1:0] period_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic preset_done_reg;
  wew_state_t state_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic ew_hit;
  logic wrap_hit;
  logic [WEW_CNT_W-1:0] ew_target;

  // Offset index decode shared by read and write paths
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction : word_idx

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction : hit

  wew_tick u_tick
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_o(tick)
  );

  // Address phase capture; the slave never waits so data phase is one cycle
  wire addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
  wire wr_now = wr_pend_reg;
  wire [31:0] wd = HWDATA_I;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_ok && HWRITE_I;
      wr_idx_reg <= word_idx(HADDR_I);
    end
  end

  // Read data registered at address phase so it stands in the data phase
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      HRDATA_O <= 32'h00000000;
    end
    else if (addr_ok && !HWRITE_I)
    begin
      case (word_idx(HADDR_I))
        WEW_IDX_CTRL: HRDATA_O <= {28'h0000000, early_warning_delay_code_reg};
        WEW_IDX_ENCLR, WEW_IDX_ENSET: HRDATA_O <= {31'h0, early_warning_irq_enable_reg};
        WEW_IDX_FLAG: HRDATA_O <= {31'h0, ew_flag_reg};
        WEW_IDX_PERIOD: HRDATA_O <= {16'h0000, period_reg};
        WEW_IDX_STAT: HRDATA_O <= {30'h0, stat_reg};
        WEW_IDX_MASK: HRDATA_O <= {30'h0, mask_reg};
        default: HRDATA_O <= 32'h00000000;
      endcase
    end
  end

  // Zero wait states and always OKAY
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end

  // Delay code: preset once after reset from the user row, then software owned
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      preset_done_reg <= 1'b0;
      early_warning_delay_code_reg <= 4'h0;
    end
    else if (!preset_done_reg)
    begin
      preset_done_reg <= 1'b1;
      early_warning_delay_code_reg <= NVM_CODE_I;
    end
    else if (wr_now && hit(wr_idx_reg, WEW_IDX_CTRL))
    begin
      early_warning_delay_code_reg <= wd[3:0];
    end
  end

  // Single enable bit behind both the set and the clear views
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      early_warning_irq_enable_reg <= WEW_EN_RST;
    end
    else if (wr_now && hit(wr_idx_reg, WEW_IDX_ENCLR) && wd[WEW_EW_BIT])
    begin
      early_warning_irq_enable_reg <= 1'b0;
    end
    else if (wr_now && hit(wr_idx_reg, WEW_IDX_ENSET) && wd[WEW_EW_BIT])
    begin
      early_warning_irq_enable_reg <= 1'b1;
    end
    // A zero written holds the enable as it is
    else
    begin
      early_warning_irq_enable_reg <= early_warning_irq_enable_reg;
    end
  end

  // Period length, software chosen; wrap marks a new period
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      period_reg <= WEW_PERIOD_RST;
    end
    else if (wr_now && hit(wr_idx_reg, WEW_IDX_PERIOD))
    begin
      period_reg <= wd[WEW_CNT_W-1:0];
    end
  end

  // Reserved codes never match so no early warning is raised for them
  assign ew_target = (early_warning_delay_code_reg > WEW_CODE_MAX) ? '0 :
    WEW_BASE_CYC << early_warning_delay_code_reg;
  assign ew_hit = tick && (state_reg == WEW_RUN) && (ew_target != '0) &&
    (cnt_reg + 16'h0001 == ew_target);
  assign wrap_hit = tick && (state_reg == WEW_RUN) && (cnt_reg == period_reg);

  // Period counter on the count clock enable
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state_reg <= WEW_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        WEW_IDLE:
        begin
          cnt_reg <= '0;
          if (PERIOD_START_I)
          begin
            state_reg <= WEW_RUN;
          end
        end
        WEW_RUN:
        begin
          if (PERIOD_START_I || wrap_hit)
          begin
            cnt_reg <= '0;
          end
          else if (tick)
          begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: state_reg <= WEW_IDLE;
      endcase
    end
  end

  // Early-warning flag: set wins over a one-written clear
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ew_flag_reg <= 1'b0;
    end
    else if (ew_hit)
    begin
      ew_flag_reg <= 1'b1;
    end
    else if (wr_now && hit(wr_idx_reg, WEW_IDX_FLAG) && wd[0])
    begin
      ew_flag_reg <= 1'b0;
    end
  end

  // Sticky status: bit0 early warning, bit1 period wrap; write one clears
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      stat_reg <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == 0 && ew_hit) || (i == 1 && wrap_hit))
        begin
          stat_reg[i] <= 1'b1;
        end
        else if (wr_now && hit(wr_idx_reg, WEW_IDX_STAT) && wd[i])
        begin
          stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      mask_reg <= 2'h0;
    end
    else if (wr_now && hit(wr_idx_reg, WEW_IDX_MASK))
    begin
      mask_reg <= wd[1:0];
    end
  end

  // Interrupt outputs registered, one cycle behind their causes
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      EW_IRQ_O <= 1'b0;
      IRQ_O <= 1'b0;
    end
    else
    begin
      EW_IRQ_O <= ew_flag_reg && early_warning_irq_enable_reg;
      IRQ_O <= |(stat_reg & mask_reg);
    end
  end
endmodule : wew_top
`default_nettype wire

// ### tb/wew_top_sva.sv
// Checker of bus, reset and interrupt relations at the controller ports
`default_nettype none
module wew_top_sva
  import wew_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] NVM_CODE_I,
  input wire logic PERIOD_START_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic EW_IRQ_O,
  input wire logic IRQ_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic tk;
  logic wr_q;
  logic [7:0] idx_q;
  // Taken address phase, delayed so write data lines up with it
  assign tk = HSEL_I && HREADY_I && HTRANS_I[1];
  always_ff @(posedge CLK_I)
  begin
    wr_q <= tk && HWRITE_I;
    idx_q <= HADDR_I[9:2];
  end
  a_ready_high: assert property (HREADYOUT_O)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!HRESP_O)
    else $error("slave answered with an error");
  a_rst_quiet: assert property (disable iff (1'b0)
    RST_I |=> !IRQ_O && !EW_IRQ_O && HRDATA_O == 32'h0)
    else $error("outputs not cleared by reset");
  a_unmapped_zero: assert property (tk && !HWRITE_I && HADDR_I[9:2] > WEW_IDX_MASK
    |=> HRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_narrow: assert property (
    tk && !HWRITE_I && HADDR_I[9:2] == WEW_IDX_CTRL |=> HRDATA_O[31:4] == 28'h0)
    else $error("delay code read has upper bits");
  a_clear_drops: assert property (
    wr_q && idx_q == WEW_IDX_ENCLR && HWDATA_I[0] |-> ##[1:2] !EW_IRQ_O)
    else $error("clear write left warning irq up");
  a_zero_keeps: assert property (
    wr_q && idx_q == WEW_IDX_ENCLR && !HWDATA_I[0] && EW_IRQ_O && !PERIOD_START_I &&
    !$past(wr_q) |=> EW_IRQ_O)
    else $error("zero clear write dropped irq");
  a_mask_off: assert property (
    wr_q && idx_q == WEW_IDX_MASK && HWDATA_I[1:0] == 2'b00 |-> ##[1:2] !IRQ_O)
    else $error("masked irq still high");
  a_ew_min_gap: assert property (
    PERIOD_START_I && !EW_IRQ_O && !wr_q |=> !EW_IRQ_O [*7])
    else $error("warning irq earlier than 8 cycles");
endmodule : wew_top_sva
bind wew_top wew_top_sva u_sva (.CLK_I(CLK_I), .RST_I(RST_I), .NVM_CODE_I(NVM_CODE_I),
  .PERIOD_START_I(PERIOD_START_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
  .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .EW_IRQ_O(EW_IRQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### tb/wew_top_tb.sv
// Self-checking bench for the watchdog early-warning controller
`default_nettype none
module wew_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wew_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] nvm = 4'h5;
  logic start = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic ew_irq;
  logic irq;
  logic [31:0] rd;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  // 10 MHz clock and an edge counter for delay measurement
  initial forever #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  wew_top u_dut (.CLK_I(clk), .RST_I(rst), .NVM_CODE_I(nvm), .PERIOD_START_I(start),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .EW_IRQ_O(ew_irq), .IRQ_O(irq));
  task automatic results();
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for the slave's ready; a hang ends the run
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 64; i++)
    begin
      @(posedge clk);
      if (hready === 1'b1)
        break;
    end
    if (i == 64)
    begin
      n_mismatch++;
      results();
    end
  endtask : wait_rdy
  // One single-word transfer; byte address is the register index times four
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    haddr <= {22'h0, idx, 2'b00};
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic t_reset();
    xfer(1'b0, WEW_IDX_CTRL, 32'h0);
    chk(rd, 32'h5);
    xfer(1'b1, 8'h0F, 32'hFFFFFFFF);
    xfer(1'b0, 8'h0F, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("reset test done");
  endtask : t_reset
  // Restart the period and time the warning interrupt from that edge
  task automatic t_delay(input logic [3:0] code);
    int t0;
    int i;
    int lim;
    lim = (code > WEW_CODE_MAX) ? 64 : 20000;
    xfer(1'b1, WEW_IDX_CTRL, {28'h0, code});
    xfer(1'b1, WEW_IDX_ENSET, 32'h1);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1 t0 = cyc;
    xfer(1'b1, WEW_IDX_FLAG, 32'h1);
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end while (ew_irq !== 1'b1 && i < lim);
    if (code > WEW_CODE_MAX)
      chk({31'h0, ew_irq}, 32'h0);
    else
    begin
      chk(32'(cyc - t0), 32'((8 << code) + 1));
      xfer(1'b0, WEW_IDX_STAT, 32'h0);
      chk(rd & 32'h1, 32'h1);
      if (i == lim)
        results();
    end
    $display("delay test done code=%0d", code);
  endtask : t_delay
  task automatic t_clear();
    xfer(1'b1, WEW_IDX_ENCLR, 32'h0);
    @(posedge clk);
    #1 chk({31'h0, ew_irq}, 32'h1);
    xfer(1'b0, WEW_IDX_ENSET, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, WEW_IDX_ENCLR, 32'h1);
    xfer(1'b0, WEW_IDX_ENSET, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, WEW_IDX_ENCLR, 32'h0);
    chk(rd, 32'h0);
    #1 chk({31'h0, ew_irq}, 32'h0);
    $display("clear test done");
  endtask : t_clear
  // Status bit is still set from the delay runs: unmask, mask, unmask again, then clear it
  task automatic t_irq();
    xfer(1'b1, WEW_IDX_MASK, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1);
    xfer(1'b1, WEW_IDX_MASK, 32'h0);
    @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    xfer(1'b1, WEW_IDX_MASK, 32'h1);
    xfer(1'b1, WEW_IDX_STAT, 32'h1);
    xfer(1'b0, WEW_IDX_STAT, 32'h0);
    chk(rd & 32'h1, 32'h0);
    #1 chk({31'h0, irq}, 32'h0);
    $display("irq test done");
  endtask : t_irq
  // Short period: the counter wraps and sets the sticky wrap status bit
  task automatic t_wrap();
    xfer(1'b1, WEW_IDX_PERIOD, 32'h10);
    xfer(1'b0, WEW_IDX_PERIOD, 32'h0);
    chk(rd, 32'h10);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(posedge clk);
    xfer(1'b0, WEW_IDX_STAT, 32'h0);
    chk(rd & 32'h2, 32'h2);
    $display("wrap test done");
  endtask : t_wrap
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_delay(4'h0);
    t_clear();
    t_delay(4'h1);
    t_delay(4'h5);
    t_delay(4'hB);
    t_delay(4'hC);
    t_irq();
    t_wrap();
    results();
  end
endmodule : wew_top_tb
`default_nettype wire
